// file: shared/rif_regs.vh
// Constants shared by the radio interface fabric design files
`ifndef RIF_REGS_VH
`define RIF_REGS_VH
// ==========
// Clock and timing
`define RIF_CLK_MHZ     250
`define RIF_T15_US      15000
`define RIF_T7P5_US     7500
`define RIF_TDM_HALF    4
`define RIF_DAC_DIV     25
`define RIF_SPI_HALF    4
// ==========
// Receive frame layout
`define RIF_NBRANCH     3
`define RIF_NCHAN       6
`define RIF_NPATH       18
`define RIF_WW          16
`define RIF_WORDS       10
`define RIF_W_STAT0     6
`define RIF_W_STAT1     7
`define RIF_W_ENER0     8
`define RIF_W_ENER1     9
`define RIF_FRAME_BITS  160
// ==========
// Receive processing
`define RIF_TAPS_LOG    8
`define RIF_DECIM       10
`define RIF_GAIN_W      4
`define RIF_ENER_SHIFT  4
// ==========
// Transmit stream layout
`define RIF_TX_CARRIERS 6
`define RIF_TX_CTRL_W   8
`define RIF_TX_DATA_BITS 96
`define RIF_TX_LAST_BIT 103
// ==========
// Other ports
`define RIF_SPI_W       16
`define RIF_GPIO_W      8
`endif

// file: rtl/rif_fifo.v
// Small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rif_fifo #(
  parameter W  = 32,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire         clock_i,
  input  wire         rst_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;

  assign in_ready_o  = (cnt_r != D[AW:0]);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (push) begin
      mem[wr_r] <= in_data_i;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      // Pointers wrap by index; D must be a power of two
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/rif_fabric.v
// Radio interface fabric: receive DSP and TDM, transmit framing, timing, SPI, GPIO
`timescale 1ns/1ns
`default_nettype none
`include "rif_regs.vh"
// Functional notes
// R1 - Three receive TDM ports share one bit clock and frame sync.
// R2 - Frame: six channel, two status, two energy words.
// R3 - Transmit input: framed I and Q streams, up to six carriers.
// R4 - Extract and apply control bits after transmit sample data.
// R5 - Align transmit output frames to internal timing.
// R6 - Recover the second marker from site reference; drive it out.
// R7 - 15 ms and 7.5 ms pulses aligned to the second marker.
// R8 - Mixer shifts each of six channels to zero frequency.
// R9 - 256-tap polyphase FIR per channel, decimating by ten.
// R10 - Energy measure drives the attenuator controls.
// R11 - Independent gain for each of 18 receive paths.
// R12 - Six receiver interfaces detect and handle link faults.
// R13 - Interrupt controller signals status events.
// R14 - The processor sets up the device over a parallel bus. The code has no bus; settings arrive directly on input ports.
// R15 - Parallel words shift out serially over SPI.
// R16 - Programmable general purpose pins for the transceiver.
// R17 - Processor to host transfers are interrupt driven. The code has no transfer path; irq_o reflects only masked rx_fault_o bits.
// R18 - From sync: channel, status, then energy words.
// R19 - Fault latches flag and maskable interrupt until cleared.
module rif_fabric #(
  parameter T15_CYC  = `RIF_T15_US * `RIF_CLK_MHZ,
  parameter T7P5_CYC = `RIF_T7P5_US * `RIF_CLK_MHZ
) (
  input  wire                              clock_i,
  input  wire                              rst_i,
  input  wire [`RIF_NCHAN*`RIF_WW-1:0]     rx_sample_i,
  input  wire [`RIF_NCHAN-1:0]             rx_valid_i,
  input  wire [`RIF_NCHAN-1:0]             rx_parity_i,
  input  wire [`RIF_NCHAN-1:0]             rx_fault_clear_i,
  input  wire [`RIF_NCHAN-1:0]             irq_mask_i,
  input  wire [2*`RIF_NCHAN-1:0]           mix_step_i,
  input  wire [`RIF_NPATH*`RIF_GAIN_W-1:0] gain_i,
  input  wire [`RIF_WW-1:0]                energy_thresh_i,
  output reg                               tdm_clk_o,
  output reg                               tdm_fs_o,
  output reg  [`RIF_NBRANCH-1:0]           tdm_data_o,
  output reg  [`RIF_NCHAN-1:0]             rx_fault_o,
  output reg                               irq_o,
  output reg  [`RIF_NCHAN-1:0]             atten_o,
  input  wire                              tx_sclk_i,
  input  wire                              tx_fs_i,
  input  wire                              tx_i_i,
  input  wire                              tx_q_i,
  output reg                               tx_ready_o,
  output reg  [`RIF_TX_CTRL_W-1:0]         tx_ctrl_o,
  output reg  [`RIF_WW-1:0]                dac_i_o,
  output reg  [`RIF_WW-1:0]                dac_q_o,
  output reg                               dac_strobe_o,
  input  wire                              site_ref_i,
  output reg                               second_marker_o,
  output reg                               tick_15ms_o,
  output reg                               tick_7p5ms_o,
  input  wire [`RIF_SPI_W-1:0]             spi_data_i,
  input  wire                              spi_start_i,
  output reg                               spi_sclk_o,
  output reg                               spi_mosi_o,
  output reg                               spi_cs_n_o,
  output reg                               spi_busy_o,
  input  wire [`RIF_GPIO_W-1:0]            gpio_in_i,
  input  wire [`RIF_GPIO_W-1:0]            gpio_out_i,
  input  wire [`RIF_GPIO_W-1:0]            gpio_dir_i,
  output reg  [`RIF_GPIO_W-1:0]            gpio_o,
  output reg  [`RIF_GPIO_W-1:0]            gpio_oe_o,
  output reg  [`RIF_GPIO_W-1:0]            gpio_state_o
);
  localparam SW = 5 + `RIF_GPIO_W;
  localparam SPI_IDLE  = 2'b01;
  localparam SPI_SHIFT = 2'b10;

  // ==========
  // Pin synchronisers: value changes once stages 2 and 3 agree
  reg  [SW-1:0] s1_r;
  reg  [SW-1:0] s2_r;
  reg  [SW-1:0] s3_r;
  reg  [SW-1:0] flt_r;
  reg  [SW-1:0] flt_d_r;
  wire [SW-1:0] pins = {gpio_in_i, tx_q_i, tx_i_i, tx_fs_i, tx_sclk_i, site_ref_i};
  wire [SW-1:0] flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r | s3_r));

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r    <= {SW{1'b0}};
      s2_r    <= {SW{1'b0}};
      s3_r    <= {SW{1'b0}};
      flt_r   <= {SW{1'b0}};
      flt_d_r <= {SW{1'b0}};
    end else begin
      s1_r    <= pins;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      flt_r   <= flt_nxt;
      flt_d_r <= flt_r;
    end
  end

  wire ref_rise  = flt_r[0] & ~flt_d_r[0];
  wire sclk_rise = flt_r[1] & ~flt_d_r[1];

  // ==========
  // Receive front end per channel: fault check, mixer, FIR
  reg  [`RIF_WW-1:0] filt_r   [0:`RIF_NCHAN-1];
  reg  [`RIF_WW-1:0] energy_r [0:`RIF_NCHAN-1];
  wire [`RIF_NCHAN-1:0] bad;

  genvar c;
  generate
    for (c = 0; c < `RIF_NCHAN; c = c + 1) begin : g_ch
      reg  [`RIF_WW-1:0]        hist [0:(1<<`RIF_TAPS_LOG)-1];
      reg  [`RIF_TAPS_LOG-1:0]  ptr_r;
      reg  [1:0]                phase_r;
      reg  [3:0]                dec_r;
      reg  signed [`RIF_WW+`RIF_TAPS_LOG-1:0] acc_r;
      wire [`RIF_WW-1:0]        x = rx_sample_i[c*`RIF_WW +: `RIF_WW];
      wire signed [`RIF_WW-1:0] mixed;
      wire [`RIF_WW-1:0]        oldest = hist[ptr_r];
      wire signed [`RIF_WW+`RIF_TAPS_LOG-1:0] acc_nxt =
        acc_r + {{`RIF_TAPS_LOG{mixed[`RIF_WW-1]}}, mixed}
              - {{`RIF_TAPS_LOG{oldest[`RIF_WW-1]}}, oldest};
      wire [`RIF_WW-1:0]        y = acc_nxt[`RIF_WW+`RIF_TAPS_LOG-1:`RIF_TAPS_LOG];
      wire [`RIF_WW-1:0]        mag = y[`RIF_WW-1] ? (~y + 1'b1) : y;
      wire good = rx_valid_i[c] & ~bad[c];

      assign bad[c] = rx_valid_i[c] & ((^x) != rx_parity_i[c]); // see R12
      // Cosine leg of a quarter-rate rotator: no multiplier needed
      assign mixed = phase_r[0] ? {`RIF_WW{1'b0}} : (phase_r[1] ? (~x + 1'b1) : x); // see R8

      always @(posedge clock_i) begin
        if (good) begin
          hist[ptr_r] <= mixed;
        end
      end

      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          ptr_r       <= {`RIF_TAPS_LOG{1'b0}};
          phase_r     <= 2'h0;
          dec_r       <= 4'h0;
          acc_r       <= {(`RIF_WW+`RIF_TAPS_LOG){1'b0}};
          filt_r[c]   <= {`RIF_WW{1'b0}};
          energy_r[c] <= {`RIF_WW{1'b0}};
        end else if (good) begin
          // Faulty samples are discarded so they never enter the filter
          phase_r <= phase_r + mix_step_i[2*c +: 2]; // see R8
          ptr_r   <= ptr_r + 1'b1;
          acc_r   <= acc_nxt; // see R9
          if (dec_r == `RIF_DECIM - 1) begin
            dec_r       <= 4'h0;
            filt_r[c]   <= y; // see R9
            energy_r[c] <= energy_r[c] - (energy_r[c] >> `RIF_ENER_SHIFT)
                           + (mag >> `RIF_ENER_SHIFT); // see R10
          end else begin
            dec_r <= dec_r + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ==========
  // Fault flags, interrupt, attenuators
  integer k;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_fault_o <= {`RIF_NCHAN{1'b0}};
      irq_o      <= 1'b0;
      atten_o    <= {`RIF_NCHAN{1'b0}};
    end else begin
      // Set wins over a clear in the same cycle
      rx_fault_o <= (rx_fault_o & ~rx_fault_clear_i) | bad; // see R19
      irq_o      <= |(rx_fault_o & irq_mask_i); // see R13 R17
      for (k = 0; k < `RIF_NCHAN; k = k + 1) begin
        atten_o[k] <= (energy_r[k] > energy_thresh_i); // see R10
      end
    end
  end

  // ==========
  // Receive TDM serialisers, one per branch
  reg  [`RIF_TDM_HALF-1:0] tdiv_r;
  reg  [7:0]               tbit_r;
  reg  [`RIF_WW-1:0]       tsr_r [0:`RIF_NBRANCH-1];
  reg  [7:0]               fcnt_r;
  wire                     tfall = tdm_clk_o & (tdiv_r == `RIF_TDM_HALF - 1);
  wire [7:0]               tbit_nxt = (tbit_r == `RIF_FRAME_BITS - 1) ? 8'h00 : tbit_r + 1'b1;
  wire [3:0]               tword = tbit_nxt[7:4];

  genvar b;
  generate
    for (b = 0; b < `RIF_NBRANCH; b = b + 1) begin : g_br
      wire [`RIF_WORDS*`RIF_WW-1:0] fw;
      for (c = 0; c < `RIF_NCHAN; c = c + 1) begin : g_w
        wire [`RIF_GAIN_W-1:0] g = gain_i[(b*`RIF_NCHAN+c)*`RIF_GAIN_W +: `RIF_GAIN_W];
        assign fw[c*`RIF_WW +: `RIF_WW] = $signed(filt_r[c]) >>> g; // see R11
      end
      assign fw[`RIF_W_STAT0*`RIF_WW +: `RIF_WW] = {rx_fault_o, atten_o, 4'h0}; // see R2
      assign fw[`RIF_W_STAT1*`RIF_WW +: `RIF_WW] = {tx_ctrl_o, fcnt_r};
      assign fw[`RIF_W_ENER0*`RIF_WW +: `RIF_WW] = energy_r[2*b];
      assign fw[`RIF_W_ENER1*`RIF_WW +: `RIF_WW] = energy_r[2*b+1];

      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          tsr_r[b]      <= {`RIF_WW{1'b0}};
          tdm_data_o[b] <= 1'b0;
        end else if (tfall) begin
          // Word boundaries walk channel, status, energy from the sync bit
          if (tbit_nxt[3:0] == 4'h0) begin
            tsr_r[b]      <= {fw[{tword, 4'h0} +: `RIF_WW - 1], 1'b0}; // see R18
            tdm_data_o[b] <= fw[{tword, 4'hF}]; // see R1
          end else begin
            tsr_r[b]      <= {tsr_r[b][`RIF_WW-2:0], 1'b0};
            tdm_data_o[b] <= tsr_r[b][`RIF_WW-1];
          end
        end
      end
    end
  endgenerate

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tdiv_r    <= {`RIF_TDM_HALF{1'b0}};
      tbit_r    <= `RIF_FRAME_BITS - 1;
      tdm_clk_o <= 1'b0;
      tdm_fs_o  <= 1'b0;
      fcnt_r    <= 8'h00;
    end else begin
      tdiv_r <= (tdiv_r == `RIF_TDM_HALF - 1) ? {`RIF_TDM_HALF{1'b0}} : tdiv_r + 1'b1;
      if (tdiv_r == `RIF_TDM_HALF - 1) begin
        tdm_clk_o <= ~tdm_clk_o; // see R1
      end
      if (tfall) begin
        tbit_r   <= tbit_nxt;
        tdm_fs_o <= (tbit_nxt == 8'h00); // see R18
        if (tbit_nxt == 8'h00) begin
          fcnt_r <= fcnt_r + 1'b1;
        end
      end
    end
  end

  // ==========
  // Transmit deframer, buffer and DAC alignment
  reg  [6:0]          xbit_r;
  reg                 xact_r;
  reg  [`RIF_WW-1:0]  xi_r;
  reg  [`RIF_WW-1:0]  xq_r;
  reg                 push_r;
  reg  [7:0]          dacdiv_r;
  reg  [2:0]          dcnt_r;
  reg                 drun_r;
  wire                f_ready;
  wire                f_valid;
  wire [2*`RIF_WW-1:0] f_data;
  wire                dac_tick = (dacdiv_r == `RIF_DAC_DIV - 1);
  wire                frame_go = tfall & (tbit_nxt == 8'h00);
  wire                pop = drun_r & dac_tick & f_valid;
  wire [6:0]          xpos = flt_r[2] ? 7'h00 : xbit_r;

  rif_fifo #(.W(2*`RIF_WW), .D(4), .AW(2)) u_txbuf (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_r),
    .in_ready_o  (f_ready),
    .in_data_i   ({xi_r, xq_r}),
    .out_valid_o (f_valid),
    .out_ready_i (pop),
    .out_data_o  (f_data)
  );

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      xbit_r       <= 7'h00;
      xact_r       <= 1'b0;
      xi_r         <= {`RIF_WW{1'b0}};
      xq_r         <= {`RIF_WW{1'b0}};
      push_r       <= 1'b0;
      tx_ready_o   <= 1'b0;
      tx_ctrl_o    <= {`RIF_TX_CTRL_W{1'b0}};
      dacdiv_r     <= 8'h00;
      dcnt_r       <= 3'h0;
      drun_r       <= 1'b0;
      dac_i_o      <= {`RIF_WW{1'b0}};
      dac_q_o      <= {`RIF_WW{1'b0}};
      dac_strobe_o <= 1'b0;
    end else begin
      push_r     <= 1'b0;
      tx_ready_o <= f_ready;
      if (sclk_rise & (flt_r[2] | xact_r)) begin
        xi_r   <= {xi_r[`RIF_WW-2:0], flt_r[3]}; // see R3
        xq_r   <= {xq_r[`RIF_WW-2:0], flt_r[4]};
        xbit_r <= xpos + 1'b1;
        xact_r <= (xpos != `RIF_TX_LAST_BIT);
        if (xpos < `RIF_TX_DATA_BITS && xpos[3:0] == 4'hF) begin
          push_r <= 1'b1; // a word met by a full buffer is lost
        end
        if (xpos == `RIF_TX_LAST_BIT) begin
          tx_ctrl_o <= {xi_r[`RIF_TX_CTRL_W-2:0], flt_r[3]}; // see R4
        end
      end
      dacdiv_r <= dac_tick ? 8'h00 : dacdiv_r + 1'b1;
      // Output frames start only on the internal frame boundary
      if (frame_go & f_valid & ~drun_r) begin
        drun_r <= 1'b1; // see R5
        dcnt_r <= 3'h0;
      end else if (pop) begin
        dcnt_r <= dcnt_r + 1'b1;
        drun_r <= (dcnt_r != `RIF_TX_CARRIERS - 1);
      end
      dac_strobe_o <= pop;
      if (pop) begin
        dac_i_o <= f_data[2*`RIF_WW-1:`RIF_WW];
        dac_q_o <= f_data[`RIF_WW-1:0];
      end
    end
  end

  // ==========
  // Second marker and frame timing pulses
  reg [31:0] c15_r;
  reg [31:0] c7_r;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      c15_r           <= 32'h0;
      c7_r            <= 32'h0;
      second_marker_o <= 1'b0;
      tick_15ms_o     <= 1'b0;
      tick_7p5ms_o    <= 1'b0;
    end else begin
      second_marker_o <= ref_rise; // see R6
      c15_r           <= (ref_rise | (c15_r == T15_CYC - 1)) ? 32'h0 : c15_r + 1'b1; // see R7
      c7_r            <= (ref_rise | (c7_r == T7P5_CYC - 1)) ? 32'h0 : c7_r + 1'b1;
      tick_15ms_o     <= ref_rise | (c15_r == T15_CYC - 1);
      tick_7p5ms_o    <= ref_rise | (c7_r == T7P5_CYC - 1);
    end
  end

  // ==========
  // SPI shifter and GPIO
  reg [1:0]             sst_r;
  reg [`RIF_SPI_W-1:0]  ssr_r;
  reg [4:0]             sbit_r;
  reg [2:0]             sdiv_r;
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sst_r        <= SPI_IDLE;
      ssr_r        <= {`RIF_SPI_W{1'b0}};
      sbit_r       <= 5'h00;
      sdiv_r       <= 3'h0;
      spi_sclk_o   <= 1'b0;
      spi_mosi_o   <= 1'b0;
      spi_cs_n_o   <= 1'b1;
      spi_busy_o   <= 1'b0;
      gpio_o       <= {`RIF_GPIO_W{1'b0}};
      gpio_oe_o    <= {`RIF_GPIO_W{1'b0}};
      gpio_state_o <= {`RIF_GPIO_W{1'b0}};
    end else begin
      gpio_o       <= gpio_out_i; // see R16
      gpio_oe_o    <= gpio_dir_i;
      gpio_state_o <= flt_r[SW-1:5];
      case (sst_r)
        SPI_IDLE: begin
          if (spi_start_i) begin
            sst_r      <= SPI_SHIFT; // see R15
            ssr_r      <= {spi_data_i[`RIF_SPI_W-2:0], 1'b0};
            spi_mosi_o <= spi_data_i[`RIF_SPI_W-1];
            spi_cs_n_o <= 1'b0;
            spi_busy_o <= 1'b1;
            sbit_r     <= 5'h00;
            sdiv_r     <= 3'h0;
          end
        end
        SPI_SHIFT: begin
          sdiv_r <= (sdiv_r == `RIF_SPI_HALF - 1) ? 3'h0 : sdiv_r + 1'b1;
          if (sdiv_r == `RIF_SPI_HALF - 1) begin
            spi_sclk_o <= ~spi_sclk_o;
            if (spi_sclk_o) begin
              if (sbit_r == `RIF_SPI_W - 1) begin
                sst_r      <= SPI_IDLE;
                spi_cs_n_o <= 1'b1;
                spi_busy_o <= 1'b0;
                spi_mosi_o <= 1'b0;
              end else begin
                sbit_r     <= sbit_r + 1'b1;
                spi_mosi_o <= ssr_r[`RIF_SPI_W-1];
                ssr_r      <= {ssr_r[`RIF_SPI_W-2:0], 1'b0};
              end
            end
          end
        end
        default: begin
          sst_r <= SPI_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verif/rif_tx_source.sv
// Transmit stream source standing in for the baseband processor
`timescale 1ns/1ns
`default_nettype none
module rif_tx_source #(
  parameter int HALF_NS = 24
) (
  output var logic tx_sclk_o = 1'h0,
  output var logic tx_fs_o   = 1'h0,
  output var logic tx_i_o    = 1'h0,
  output var logic tx_q_o    = 1'h1
);
  // ==========
  // One frame: six I/Q words, then the control byte on I
  task automatic send_frame(input logic [95:0] iw, input logic [95:0] qw, input logic [7:0] ctrl);
    logic [103:0] ibits;
    ibits = {iw, ctrl};
    for (int n = 0; n < 104; n++) begin
      tx_fs_o = (n == 0);
      tx_i_o = ibits[103-n];
      tx_q_o = (n < 96) ? qw[95-n] : ~tx_q_o;
      #HALF_NS tx_sclk_o = 1'h1;
      #HALF_NS tx_sclk_o = 1'h0;
    end
    // Idle: clock still, data inverted
    tx_fs_o = 1'h0;
    tx_i_o = ~tx_i_o;
    tx_q_o = ~tx_q_o;
  endtask
endmodule
`default_nettype wire

// file: verif/rif_fabric_asserts.sv
// Concurrent checks on the radio interface fabric ports
`timescale 1ns/1ns
`default_nettype none
`include "rif_regs.vh"
module rif_asserts #(
  parameter int T15_CYC  = 300,
  parameter int T7P5_CYC = 150
) (
  input wire logic                          clock_i,
  input wire logic                          rst_i,
  input wire logic [`RIF_NCHAN*`RIF_WW-1:0] rx_sample_i,
  input wire logic [`RIF_NCHAN-1:0]         rx_valid_i,
  input wire logic [`RIF_NCHAN-1:0]         rx_parity_i,
  input wire logic [`RIF_NCHAN-1:0]         rx_fault_clear_i,
  input wire logic [`RIF_NCHAN-1:0]         irq_mask_i,
  input wire logic [`RIF_NCHAN-1:0]         rx_fault_o,
  input wire logic                          irq_o,
  input wire logic                          tdm_clk_o,
  input wire logic                          tdm_fs_o,
  input wire logic                          dac_strobe_o,
  input wire logic                          second_marker_o,
  input wire logic                          tick_15ms_o,
  input wire logic                          tick_7p5ms_o,
  input wire logic [`RIF_SPI_W-1:0]         spi_data_i,
  input wire logic                          spi_start_i,
  input wire logic                          spi_sclk_o,
  input wire logic                          spi_mosi_o,
  input wire logic                          spi_cs_n_o,
  input wire logic                          spi_busy_o
);
  logic [`RIF_NCHAN-1:0] bad_par;
  always_comb begin
    for (int c = 0; c < `RIF_NCHAN; c++) begin
      bad_par[c] = rx_valid_i[c] & ((^rx_sample_i[c*`RIF_WW +: `RIF_WW]) != rx_parity_i[c]);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Serial control link
  sequence s_spi_go;
    !spi_busy_o && spi_start_i;
  endsequence
  sequence s_spi_first;
    !spi_cs_n_o && spi_busy_o && !spi_sclk_o && spi_mosi_o == $past(spi_data_i[15]);
  endsequence
  a_spi_start: assert property (s_spi_go |=> s_spi_first) else $error("spi start");
  a_spi_half_period: assert property ($rose(spi_sclk_o) |-> spi_sclk_o[*4] ##1 !spi_sclk_o) else $error("spi sclk");
  a_spi_frame: assert property ((spi_busy_o == !spi_cs_n_o) && (!spi_cs_n_o || !spi_sclk_o)) else $error("spi frame");
  // ==========
  // Faults and interrupt
  a_fault_set: assert property (bad_par != 0 |=> (rx_fault_o & $past(bad_par)) == $past(bad_par)) else $error("fault set");
  a_fault_sticky: assert property ((($past(rx_fault_o) & ~rx_fault_o & ~$past(rx_fault_clear_i))
    | (rx_fault_o & ~$past(rx_fault_o) & ~$past(bad_par))) == 0) else $error("fault hold");
  a_irq_follow: assert property (1 |=> irq_o == $past(|(rx_fault_o & irq_mask_i))) else $error("irq");
  // ==========
  // Timing pulses, TDM framing, DAC pacing
  a_tick_mark: assert property (second_marker_o |-> tick_15ms_o && tick_7p5ms_o) else $error("mark align");
  a_tick_half: assert property (second_marker_o |-> ##T7P5_CYC tick_7p5ms_o) else $error("7.5 tick");
  a_tick_full: assert property (second_marker_o |-> ##T15_CYC tick_15ms_o) else $error("15 tick");
  a_tdm_clock: assert property ($rose(tdm_clk_o) |-> tdm_clk_o[*4] ##1 !tdm_clk_o) else $error("tdm clk");
  a_tdm_sync: assert property ($rose(tdm_fs_o) |-> tdm_fs_o[*8] ##1 !tdm_fs_o) else $error("tdm fs");
  a_dac_pace: assert property (dac_strobe_o |=> !dac_strobe_o[*8]) else $error("dac strobe");
endmodule
bind rif_fabric rif_asserts #(.T15_CYC(T15_CYC), .T7P5_CYC(T7P5_CYC)) i_rif_asserts (
  .clock_i(clock_i), .rst_i(rst_i), .rx_sample_i(rx_sample_i), .rx_valid_i(rx_valid_i),
  .rx_parity_i(rx_parity_i), .rx_fault_clear_i(rx_fault_clear_i), .irq_mask_i(irq_mask_i),
  .rx_fault_o(rx_fault_o), .irq_o(irq_o), .tdm_clk_o(tdm_clk_o), .tdm_fs_o(tdm_fs_o),
  .dac_strobe_o(dac_strobe_o), .second_marker_o(second_marker_o), .tick_15ms_o(tick_15ms_o),
  .tick_7p5ms_o(tick_7p5ms_o), .spi_data_i(spi_data_i), .spi_start_i(spi_start_i),
  .spi_sclk_o(spi_sclk_o), .spi_mosi_o(spi_mosi_o), .spi_cs_n_o(spi_cs_n_o), .spi_busy_o(spi_busy_o));
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the radio interface fabric
`timescale 1ns/1ns
`default_nettype none
`include "rif_regs.vh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module tb;
  localparam logic [15:0] SAMP = 16'hB3E0;
  logic clk = 1'h0;
  logic rst, site_ref, spi_start;
  logic [95:0] sample;
  logic [5:0] valid, parity, clr, mask;
  logic [71:0] gain;
  logic [15:0] thresh, spi_data, dac_i, dac_q;
  logic [7:0] gpio_out, gpio_dir, gpio_ext, tx_ctrl, gpio_o, gpio_oe, gpio_st;
  logic [5:0] fault, atten;
  logic [2:0] tdm_data;
  logic tdm_clk, tdm_fs, irq, sclk, fs, ti, tq, tx_ready, dac_stb, marker, t15, t7, spi_sclk, mosi, cs_n, busy;
  wire [7:0] gpio_in = (gpio_oe & gpio_o) | (~gpio_oe & gpio_ext);
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  rif_fabric #(.T15_CYC(300), .T7P5_CYC(150)) i_rif_fabric (.clock_i(clk), .rst_i(rst),
    .rx_sample_i(sample), .rx_valid_i(valid), .rx_parity_i(parity), .rx_fault_clear_i(clr),
    .irq_mask_i(mask), .mix_step_i(12'h000), .gain_i(gain), .energy_thresh_i(thresh), .tdm_clk_o(tdm_clk),
    .tdm_fs_o(tdm_fs), .tdm_data_o(tdm_data), .rx_fault_o(fault), .irq_o(irq), .atten_o(atten),
    .tx_sclk_i(sclk), .tx_fs_i(fs), .tx_i_i(ti), .tx_q_i(tq), .tx_ready_o(tx_ready), .tx_ctrl_o(tx_ctrl),
    .dac_i_o(dac_i), .dac_q_o(dac_q), .dac_strobe_o(dac_stb), .site_ref_i(site_ref),
    .second_marker_o(marker), .tick_15ms_o(t15), .tick_7p5ms_o(t7), .spi_data_i(spi_data),
    .spi_start_i(spi_start), .spi_sclk_o(spi_sclk), .spi_mosi_o(mosi), .spi_cs_n_o(cs_n),
    .spi_busy_o(busy), .gpio_in_i(gpio_in), .gpio_out_i(gpio_out), .gpio_dir_i(gpio_dir),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .gpio_state_o(gpio_st));
  rif_tx_source i_rif_tx_source (.tx_sclk_o(sclk), .tx_fs_o(fs), .tx_i_o(ti), .tx_q_o(tq));
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  // ==========
  // Scenarios
  task automatic t_gpio;
    @(negedge clk) {gpio_out, gpio_dir, gpio_ext} = 24'h5A0F93;
    repeat (6) @(negedge clk);
    `CHK("gpio drive", 16'h5A0F, {gpio_o, gpio_oe})
    `CHK("gpio level", 8'h9A, gpio_st)
  endtask
  task automatic t_spi;
    logic [15:0] got;
    int n = 0;
    logic prev = 1'h0;
    @(negedge clk) {spi_data, spi_start} = {16'hC3A5, 1'h1};
    @(negedge clk) {spi_data, spi_start} = 17'h0;
    for (int k = 0; k < 300 && busy; k++) begin
      @(negedge clk);
      if (spi_sclk && !prev) begin
        got = {got[14:0], mosi};
        n++;
      end
      prev = spi_sclk;
      spi_start = (k == 20);
    end
    `CHK("spi word", 16'hC3A5, got)
    `CHK("spi bits", 16, n)
    `CHK("spi idle", 2'h2, {cs_n, busy})
  endtask
  task automatic t_time;
    @(negedge clk) site_ref = 1'h1;
    for (int k = 0; k < 30 && marker !== 1'h1; k++) @(negedge clk);
    `CHK("marker ticks", 3'h7, {marker, t15, t7})
    repeat (150) @(negedge clk);
    `CHK("half tick", 2'h1, {t15, t7})
    site_ref = 1'h0;
    repeat (150) @(negedge clk);
    `CHK("full tick", 2'h3, {t15, t7})
  endtask
  task automatic t_tx;
    logic [0:5][15:0] iw, qw;
    int n = 0;
    logic full = 1'h0;
    for (int k = 0; k < 6; k++) begin
      iw[k] = 16'h1357 * 16'(k + 1);
      qw[k] = ~iw[k];
    end
    for (int k = 0; k < 2000 && tdm_fs; k++) @(negedge clk);
    for (int k = 0; k < 2000 && !tdm_fs; k++) @(negedge clk);
    fork
      i_rif_tx_source.send_frame(iw, qw, 8'hA5);
      for (int k = 0; k < 3000; k++) begin
        @(negedge clk);
        full |= !tx_ready;
        if (dac_stb) begin
          `CHK("dac pair", {iw[n], qw[n]}, {dac_i, dac_q})
          n++;
        end
      end
    join
    `CHK("dac words", 4, n)
    `CHK("buffer full then free", 2'h3, {full, tx_ready})
    `CHK("tx control", 8'hA5, tx_ctrl)
  endtask
  task automatic t_fault;
    @(negedge clk) {mask, valid} = {6'h10, 6'h3F};
    repeat (270) @(negedge clk);
    `CHK("no fault", 6'h00, fault)
    {parity, valid} = {~parity, 6'h04};
    @(negedge clk) valid = 6'h00;
    `CHK("fault latch", 7'h04, {irq, fault})
    @(negedge clk) `CHK("masked irq", 1'h0, irq)
    valid = 6'h10;
    @(negedge clk) valid = 6'h00;
    @(negedge clk) `CHK("fault irq", 7'h54, {irq, fault})
    {parity, clr} = {~parity, 6'h10};
    @(negedge clk) clr = 6'h00;
    @(negedge clk) `CHK("fault clear", 7'h04, {irq, fault})
  endtask
  task automatic t_tdm;
    logic [0:2][159:0] fr;
    int n = 0;
    logic prev = 1'h1;
    for (int k = 0; k < 4000 && n < 160; k++) begin
      @(negedge clk);
      if (tdm_clk && !prev && (n > 0 || tdm_fs)) begin
        for (int b = 0; b < 3; b++) fr[b] = {fr[b][158:0], tdm_data[b]};
        n++;
      end
      prev = tdm_clk;
    end
    `CHK("frame bits", 160, n)
    for (int b = 0; b < 3; b++) begin
      for (int c = 0; c < 6; c++) `CHK("channel word", 16'($signed(SAMP) >>> b), fr[b][159-16*c -: 16])
      `CHK("status word", 16'h1000, fr[b][63:48])
      `CHK("control echo", 8'hA5, fr[b][47:40])
    end
  endtask
  initial begin
    {rst, site_ref, spi_start, spi_data} = {3'h4, 16'h0};
    {sample, parity, valid, clr, mask} = {{6{SAMP}}, {6{^SAMP}}, 18'h0};
    {thresh, gpio_out, gpio_dir, gpio_ext} = {16'hFFFF, 24'h0};
    for (int p = 0; p < 18; p++) gain[p*4 +: 4] = 4'(p / 6);
    repeat (6) @(posedge clk);
    `CHK("reset outputs", 22'h000001, {tdm_clk, tdm_fs, irq, dac_stb, marker, busy, fault, tx_ctrl, cs_n})
    @(negedge clk) rst = 1'h0;
    t_gpio();
    t_spi();
    t_time();
    t_tx();
    t_fault();
    t_tdm();
    conclude();
  end
endmodule
`default_nettype wire
